// ### rtl/segxl_translator.sv
// Contract
// RULE1 - Reset starts in real-address mode; tables used only after protected switch.
// RULE2 - In protected mode every access resolves through global or local table descriptor.
// RULE3 - Selector splits into table index, table-select flag and requested privilege.
// RULE4 - Fetched descriptor supplies base, access rights, type and usage bits.
// RULE5 - Linear address is the descriptor base plus supplied offset.
// RULE6 - Code, data or stack access proceeds only if reachable from current privilege.
// RULE7 - Current privilege follows the executing code segment, updating when it changes.
// RULE8 - Global table pointer holds global table base, used for global selectors.
// RULE9 - Local table pointer holds local table address, used for local selectors.
// RULE10 - Addresses are byte granular; one address names first byte accessed.
// RULE11 - Fault unable to report an accurate error code reports zero.
// RULE12 - Failed privilege check aborts access and raises general protection fault.
`timescale 1ns/1ns
module segxl_translator
   import segxl_pkg::*;
(
   input  wire logic              clk,           // Core clock
   input  wire logic              rst_n,         // Async reset, active low
   input  wire logic              prot_enter,    // Pulse: switch to protected mode
   input  wire logic              gtp_load,      // Pulse: load global table pointer
   input  wire logic [ADDR_W-1:0] gtp_base,      // Global table base
   input  wire logic              ltp_load,      // Pulse: load local table pointer
   input  wire logic [ADDR_W-1:0] ltp_base,      // Local table base
   input  wire logic              ltp_clear,     // Pulse: no local table
   input  wire logic              req_valid,     // Access request
   input  wire logic [SEL_W-1:0]  req_selector,  // Segment selector
   input  wire logic [ADDR_W-1:0] req_offset,    // Byte offset
   input  wire segxl_kind_t       req_kind,      // Code, data or stack
   output logic                   req_ready,     // Idle, request taken
   output logic                   mem_req,       // Descriptor read strobe
   output logic [ADDR_W-1:0]      mem_addr,      // Descriptor byte address
   input  wire logic              mem_rvalid,    // Descriptor data valid
   input  wire logic [DESC_W-1:0] mem_rdata,     // Descriptor data
   output logic                   rsp_valid,     // Answer pulse
   output logic [ADDR_W-1:0]      rsp_linear,    // Linear byte address
   output logic                   rsp_gp_fault,  // General protection fault
   output logic [15:0]            rsp_err_code,  // Fault error code
   output logic [3:0]             rsp_seg_type,  // Descriptor type field
   output logic [1:0]             current_privilege_level,           // Current privilege level
   output logic                   prot_mode      // Protected mode active
);
   segxl_state_t      state_ff, nxt_state;
   logic              prot_ff, nxt_prot;
   logic [1:0]        cpl_ff, nxt_cpl;
   logic [ADDR_W-1:0] gtp_ff, nxt_gtp;
   logic [ADDR_W-1:0] ltp_ff, nxt_ltp;
   logic              ltp_vld_ff, nxt_ltp_vld;
   logic [SEL_W-1:0]  sel_ff, nxt_sel;
   logic [ADDR_W-1:0] off_ff, nxt_off;
   segxl_kind_t       kind_ff, nxt_kind;
   logic              ready_ff, nxt_ready;
   logic              mreq_ff, nxt_mreq;
   logic [ADDR_W-1:0] maddr_ff, nxt_maddr;
   logic              rv_ff, nxt_rv;
   logic [ADDR_W-1:0] lin_ff, nxt_lin;
   logic              gp_ff, nxt_gp;
   logic [15:0]       err_ff, nxt_err;
   logic [3:0]        type_ff, nxt_type;

   logic [12:0]       idx;
   logic              sel_local;
   logic [1:0]        sel_rpl;
   logic [ADDR_W-1:0] tbl_base;
   logic [ADDR_W-1:0] desc_base;
   logic [1:0]        desc_dpl;
   logic [3:0]        desc_type;
   logic              desc_pres;
   logic              desc_conf;
   logic              allow;

   // Selector fields of the request being taken
   always_comb begin
      idx       = req_selector[SEL_W-1:SEL_IDX_LSB];                       // [RULE3]
      sel_local = req_selector[SEL_TI_BIT];                                // [RULE3]
      sel_rpl   = req_selector[SEL_RPL_LSB +: 2];                          // [RULE3]
      tbl_base  = sel_local ? ltp_ff : gtp_ff;                             // [RULE8] [RULE9]
   end

   // Descriptor fields
   always_comb begin
      desc_base = mem_rdata[DSC_BASE_LSB +: ADDR_W];                       // [RULE4]
      desc_dpl  = mem_rdata[DSC_DPL_LSB +: 2];                             // [RULE4]
      desc_type = mem_rdata[DSC_TYPE_LSB +: 4];                            // [RULE4]
      desc_pres = mem_rdata[DSC_PRES_BIT];                                 // [RULE4]
      desc_conf = mem_rdata[DSC_CONF_BIT];                                 // [RULE4]
   end

   segxl_priv_check u_priv (
      .current_privilege_level     (cpl_ff),
      .rpl     (sel_ff[SEL_RPL_LSB +: 2]),
      .dpl     (desc_dpl),
      .present (desc_pres),
      .conform (desc_conf),
      .kind    (kind_ff),
      .allow   (allow)
   );

   // Mode and table pointers
   always_comb begin
      nxt_prot    = prot_ff | prot_enter;                                  // [RULE1]
      nxt_gtp     = gtp_load ? gtp_base : gtp_ff;                          // [RULE8]
      nxt_ltp     = ltp_load ? ltp_base : ltp_ff;                          // [RULE9]
      nxt_ltp_vld = ltp_vld_ff;
      if (ltp_load) begin
         nxt_ltp_vld = 1'b1;
      end else if (ltp_clear) begin
         nxt_ltp_vld = 1'b0;
      end
   end

   // Translation sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_sel   = sel_ff;
      nxt_off   = off_ff;
      nxt_kind  = kind_ff;
      nxt_mreq  = 1'b0;
      nxt_maddr = maddr_ff;
      nxt_rv    = 1'b0;
      nxt_lin   = lin_ff;
      nxt_gp    = gp_ff;
      nxt_err   = err_ff;
      nxt_type  = type_ff;
      nxt_cpl   = cpl_ff;
      case (state_ff)
         SEGXL_IDLE: begin
            if (req_valid && ready_ff) begin
               nxt_sel  = req_selector;
               nxt_off  = req_offset;
               nxt_kind = req_kind;
               if (!prot_ff) begin
                  // Real-address mode: paragraph base plus offset
                  nxt_rv   = 1'b1;                                         // [RULE1]
                  nxt_lin  = ADDR_W'({req_selector, REAL_SHIFT'(0)}) + req_offset; // [RULE10]
                  nxt_gp   = 1'b0;
                  nxt_err  = ERR_ZERO;
                  nxt_type = 4'h0;
               end else if (!sel_local && idx == 13'h0000) begin
                  // Null global selector: no descriptor to name
                  nxt_rv   = 1'b1;
                  nxt_gp   = 1'b1;
                  nxt_err  = ERR_ZERO;                                     // [RULE11]
                  nxt_lin  = BASE_RST;
                  nxt_type = 4'h0;
               end else if (sel_local && !ltp_vld_ff) begin
                  // Local table absent: no accurate code possible
                  nxt_rv   = 1'b1;
                  nxt_gp   = 1'b1;
                  nxt_err  = ERR_ZERO;                                     // [RULE11]
                  nxt_lin  = BASE_RST;
                  nxt_type = 4'h0;
               end else begin
                  nxt_state = SEGXL_FETCH;                                 // [RULE2]
                  nxt_mreq  = 1'b1;
                  nxt_maddr = tbl_base + ADDR_W'({idx, DSC_BYTES_SH'(0)}); // [RULE8] [RULE9]
               end
            end
         end
         SEGXL_FETCH: begin
            nxt_state = SEGXL_WAIT;
         end
         SEGXL_WAIT: begin
            if (mem_rvalid) begin
               nxt_state = SEGXL_IDLE;
               nxt_rv    = 1'b1;
               nxt_type  = desc_type;                                      // [RULE4]
               if (allow) begin                                            // [RULE6]
                  nxt_gp  = 1'b0;
                  nxt_err = ERR_ZERO;
                  nxt_lin = desc_base + off_ff;                            // [RULE5] [RULE10]
                  if (kind_ff == SEGXL_KIND_CODE && !desc_conf) begin
                     nxt_cpl = desc_dpl;                                   // [RULE7]
                  end
               end else begin
                  nxt_gp  = 1'b1;                                          // [RULE12]
                  nxt_err = sel_ff & ERR_MASK;                             // [RULE12]
                  nxt_lin = BASE_RST;                                      // [RULE12]
               end
            end
         end
         default: begin
            nxt_state = SEGXL_IDLE;
         end
      endcase
      nxt_ready = (nxt_state == SEGXL_IDLE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= SEGXL_IDLE;
         prot_ff    <= 1'b0;                                               // [RULE1]
         cpl_ff     <= CPL_RST;
         gtp_ff     <= BASE_RST;
         ltp_ff     <= BASE_RST;
         ltp_vld_ff <= 1'b0;
         sel_ff     <= 16'h0000;
         off_ff     <= BASE_RST;
         kind_ff    <= SEGXL_KIND_DATA;
         ready_ff   <= 1'b1;
         mreq_ff    <= 1'b0;
         maddr_ff   <= BASE_RST;
         rv_ff      <= 1'b0;
         lin_ff     <= BASE_RST;
         gp_ff      <= 1'b0;
         err_ff     <= ERR_ZERO;
         type_ff    <= 4'h0;
      end else begin
         state_ff   <= nxt_state;
         prot_ff    <= nxt_prot;
         cpl_ff     <= nxt_cpl;
         gtp_ff     <= nxt_gtp;
         ltp_ff     <= nxt_ltp;
         ltp_vld_ff <= nxt_ltp_vld;
         sel_ff     <= nxt_sel;
         off_ff     <= nxt_off;
         kind_ff    <= nxt_kind;
         ready_ff   <= nxt_ready;
         mreq_ff    <= nxt_mreq;
         maddr_ff   <= nxt_maddr;
         rv_ff      <= nxt_rv;
         lin_ff     <= nxt_lin;
         gp_ff      <= nxt_gp;
         err_ff     <= nxt_err;
         type_ff    <= nxt_type;
      end
   end

   assign req_ready    = ready_ff;
   assign mem_req      = mreq_ff;
   assign mem_addr     = maddr_ff;
   assign rsp_valid    = rv_ff;
   assign rsp_linear   = lin_ff;
   assign rsp_gp_fault = gp_ff;
   assign rsp_err_code = err_ff;
   assign rsp_seg_type = type_ff;
   assign current_privilege_level          = cpl_ff;
   assign prot_mode    = prot_ff;
endmodule

// ### rtl/segxl_pkg.sv
package segxl_pkg;
   // Selector fields
   localparam int SEL_W        = 16;
   localparam int SEL_IDX_LSB  = 3;
   localparam int SEL_TI_BIT   = 2;
   localparam int SEL_RPL_LSB  = 0;
   localparam int ADDR_W       = 32;
   localparam int DESC_W       = 64;
   // Descriptor fields (block-local layout)
   localparam int DSC_BASE_LSB = 0;
   localparam int DSC_DPL_LSB  = 32;
   localparam int DSC_TYPE_LSB = 34;
   localparam int DSC_PRES_BIT = 38;
   localparam int DSC_CONF_BIT = 39;
   localparam int DSC_BYTES_SH = 3;
   localparam int REAL_SHIFT   = 4;
   // Reset values and error-code mask
   localparam logic [1:0]        CPL_RST  = 2'h0;
   localparam logic [ADDR_W-1:0] BASE_RST = 32'h0000_0000;
   localparam logic [15:0]       ERR_ZERO = 16'h0000;
   localparam logic [15:0]       ERR_MASK = 16'hFFFC;
   // Access kinds
   typedef enum logic [1:0] {
      SEGXL_KIND_CODE  = 2'b00,
      SEGXL_KIND_DATA  = 2'b01,
      SEGXL_KIND_STACK = 2'b10
   } segxl_kind_t;
   typedef enum logic [1:0] {
      SEGXL_IDLE  = 2'b00,
      SEGXL_FETCH = 2'b01,
      SEGXL_WAIT  = 2'b10
   } segxl_state_t;
endpackage

// ### rtl/segxl_priv_check.sv
`timescale 1ns/1ns
module segxl_priv_check
   import segxl_pkg::*;
(
   input  wire logic [1:0]  current_privilege_level,      // Current privilege level
   input  wire logic [1:0]  rpl,      // Requested privilege level
   input  wire logic [1:0]  dpl,      // Descriptor privilege level
   input  wire logic        present,  // Descriptor present
   input  wire logic        conform,  // Conforming code segment
   input  wire segxl_kind_t kind,     // Access kind
   output logic             allow     // Access permitted
);
   logic [1:0] eff;

   always_comb begin
      eff   = (rpl > current_privilege_level) ? rpl : current_privilege_level;
      allow = 1'b0;
      if (present) begin
         case (kind)
            SEGXL_KIND_CODE:  allow = conform ? (dpl <= current_privilege_level) : (dpl == current_privilege_level);
            SEGXL_KIND_DATA:  allow = (eff <= dpl);
            SEGXL_KIND_STACK: allow = (dpl == current_privilege_level) && (rpl == current_privilege_level);
            default:          allow = 1'b0;
         endcase
      end
   end
endmodule

// ### sim/segxl_mem_model.sv
`timescale 1ns/1ns
module segxl_mem_model
   import segxl_pkg::*;
(
   input  wire logic              clk,        // Core clock
   input  wire logic              rst_n,      // Reset, active low
   input  wire logic              mem_req,    // Entry read
   input  wire logic [DESC_W-1:0] desc,       // Entry to return
   input  wire logic              slow,       // Extra wait cycles
   output logic                   mem_rvalid, // Entry valid
   output logic [DESC_W-1:0]      mem_rdata   // Entry data
);
   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;
   always_comb begin
      nxt_cnt = (cnt_ff != 3'h0) ? cnt_ff - 3'h1 : 3'h0;
      if (mem_req) begin
         nxt_cnt = slow ? 3'h4 : 3'h1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 3'h0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
   assign mem_rvalid = (cnt_ff == 3'h1);
   // Inverse when not valid
   assign mem_rdata = mem_rvalid ? desc : ~desc;
endmodule

// ### sim/segxl_chk_sva.sv
`timescale 1ns/1ns
module segxl_chk
   import segxl_pkg::*;
(
   input wire logic              clk,          // Clock
   input wire logic              rst_n,        // Reset
   input wire logic              prot_enter,   // Mode switch
   input wire logic              gtp_load,     // Global load
   input wire logic [ADDR_W-1:0] gtp_base,     // Global base
   input wire logic              ltp_load,     // Local load
   input wire logic [ADDR_W-1:0] ltp_base,     // Local base
   input wire logic              req_valid,    // Request
   input wire logic [SEL_W-1:0]  req_selector, // Selector
   input wire logic [ADDR_W-1:0] req_offset,   // Offset
   input wire logic              req_ready,    // Idle
   input wire logic              mem_req,      // Entry read
   input wire logic [ADDR_W-1:0] mem_addr,     // Entry address
   input wire logic              mem_rvalid,   // Entry valid
   input wire logic [DESC_W-1:0] mem_rdata,    // Entry data
   input wire logic              rsp_valid,    // Answer
   input wire logic [ADDR_W-1:0] rsp_linear,   // Linear address
   input wire logic              rsp_gp_fault, // Fault
   input wire logic [15:0]       rsp_err_code, // Error code
   input wire logic [1:0]        current_privilege_level,          // Privilege
   input wire logic              prot_mode     // Protected mode
);
   logic [ADDR_W-1:0] gtp_ff, ltp_ff, off_ff, base_ff;
   logic [SEL_W-1:0]  sel_ff;
   // Shadow of the table pointers, descriptor base, selector and offset, cleared with the design
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gtp_ff  <= 32'h0000_0000;
         ltp_ff  <= 32'h0000_0000;
         base_ff <= 32'h0000_0000;
         sel_ff  <= 16'h0000;
         off_ff  <= 32'h0000_0000;
      end else begin
         if (gtp_load) gtp_ff <= gtp_base;
         if (ltp_load) ltp_ff <= ltp_base;
         if (mem_rvalid) base_ff <= mem_rdata[31:0];
         if (req_valid && req_ready) sel_ff <= req_selector;
         if (req_valid && req_ready) off_ff <= req_offset;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take_prot;
      req_valid && req_ready && prot_mode;
   endsequence
   property p_real_mode; !prot_mode && !prot_enter |=> !prot_mode; endproperty
   property p_real_lin;
      req_valid && req_ready && !prot_mode |=> rsp_valid && !rsp_gp_fault &&
         rsp_linear == {12'h000, sel_ff, 4'h0} + off_ff;
   endproperty
   property p_prot_fetch; s_take_prot |=> mem_req || (rsp_valid && rsp_gp_fault); endproperty
   property p_fetch_addr;
      s_take_prot ##1 mem_req |-> mem_addr ==
         (sel_ff[SEL_TI_BIT] ? ltp_ff : gtp_ff) + {16'h0000, sel_ff[15:3], 3'h0};
   endproperty
   property p_fetch_done; mem_req |=> !req_ready ##[1:20] rsp_valid && req_ready; endproperty
   property p_prot_lin;
      mem_rvalid |=> rsp_valid && (rsp_gp_fault || rsp_linear == base_ff + off_ff);
   endproperty
   property p_fault_out;
      rsp_valid && rsp_gp_fault |-> rsp_linear == 32'h0000_0000 &&
         (rsp_err_code == ERR_ZERO || rsp_err_code == (sel_ff & ERR_MASK));
   endproperty
   property p_null_sel;
      s_take_prot ##0 req_selector[15:2] == 14'h0000 |=>
         rsp_valid && rsp_gp_fault && rsp_err_code == ERR_ZERO;
   endproperty
   property p_cpl_hold; !rsp_valid |-> $stable(current_privilege_level); endproperty
   a_real_mode: assert property (p_real_mode) else $error("left real mode");
   a_real_lin: assert property (p_real_lin) else $error("real address");
   a_prot_fetch: assert property (p_prot_fetch) else $error("no fetch");
   a_fetch_addr: assert property (p_fetch_addr) else $error("entry address");
   a_fetch_done: assert property (p_fetch_done) else $error("fetch end");
   a_prot_lin: assert property (p_prot_lin) else $error("linear address");
   a_fault_out: assert property (p_fault_out) else $error("fault output");
   a_null_sel: assert property (p_null_sel) else $error("null selector");
   a_cpl_hold: assert property (p_cpl_hold) else $error("privilege moved");
endmodule
bind segxl_translator segxl_chk chk_u (
   .clk          (clk),
   .rst_n        (rst_n),
   .prot_enter   (prot_enter),
   .gtp_load     (gtp_load),
   .gtp_base     (gtp_base),
   .ltp_load     (ltp_load),
   .ltp_base     (ltp_base),
   .req_valid    (req_valid),
   .req_selector (req_selector),
   .req_offset   (req_offset),
   .req_ready    (req_ready),
   .mem_req      (mem_req),
   .mem_addr     (mem_addr),
   .mem_rvalid   (mem_rvalid),
   .mem_rdata    (mem_rdata),
   .rsp_valid    (rsp_valid),
   .rsp_linear   (rsp_linear),
   .rsp_gp_fault (rsp_gp_fault),
   .rsp_err_code (rsp_err_code),
   .current_privilege_level          (current_privilege_level),
   .prot_mode    (prot_mode)
);

// ### sim/tb_top.sv
`timescale 1ns/1ns
module tb_top
   import segxl_pkg::*;
;
   logic clk = 0, rst_n = 0, prot_enter = 0, gtp_load = 0, ltp_load = 0, ltp_clear = 0;
   logic req_valid = 0, slow = 0, req_ready, mem_req, mem_rvalid, rsp_valid, rsp_gp_fault;
   logic prot_mode;
   logic [ADDR_W-1:0] gtp_base = '0, ltp_base = '0, req_offset = '0, mem_addr, rsp_linear;
   logic [SEL_W-1:0]  req_selector = '0;
   logic [DESC_W-1:0] desc = '0, mem_rdata;
   logic [15:0]       rsp_err_code;
   logic [3:0]        rsp_seg_type;
   logic [1:0]        current_privilege_level;
   segxl_kind_t       req_kind = SEGXL_KIND_CODE;
   int                err_count = 0, cmp_count = 0;
   always #20 clk = ~clk;
   segxl_translator dut_u (.clk(clk), .rst_n(rst_n), .prot_enter(prot_enter),
      .gtp_load(gtp_load), .gtp_base(gtp_base), .ltp_load(ltp_load), .ltp_base(ltp_base),
      .ltp_clear(ltp_clear), .req_valid(req_valid), .req_selector(req_selector),
      .req_offset(req_offset), .req_kind(req_kind), .req_ready(req_ready),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
      .rsp_valid(rsp_valid), .rsp_linear(rsp_linear), .rsp_gp_fault(rsp_gp_fault),
      .rsp_err_code(rsp_err_code), .rsp_seg_type(rsp_seg_type), .current_privilege_level(current_privilege_level),
      .prot_mode(prot_mode));
   segxl_mem_model mem_u (.clk(clk), .rst_n(rst_n), .mem_req(mem_req), .desc(desc),
      .slow(slow), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
   task end_of_test;
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   function automatic logic [63:0] dsc(logic [31:0] b, logic [1:0] p, logic [3:0] t, logic pr);
      return {24'h00_0000, 1'b0, pr, t, p, b};
   endfunction
   task acc(input logic [15:0] s, input logic [31:0] o, input segxl_kind_t k,
            input logic [63:0] d, input logic ef, input logic [15:0] ee, input logic [31:0] el);
      int n;
      @(posedge clk);
      req_valid <= 1'b1; req_selector <= s; req_offset <= o; req_kind <= k; desc <= d;
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 20);
      if (rsp_valid !== 1'b1) begin
         err_count++;
         $display("MISMATCH %0t no answer", $time);
         end_of_test();
      end else begin
         chk(rsp_gp_fault, ef, "fault flag");
         chk(rsp_err_code, ee, "error code");
         chk(rsp_linear, el, "linear address");
         if (ef === 1'b0 && prot_mode === 1'b1) begin
            chk(rsp_seg_type, d[37:34], "segment type");
         end
      end
   endtask
   task t_real;
      chk({prot_mode, current_privilege_level, req_ready}, 32'h0000_0001, "reset state");
      acc(16'h1234, 32'h0000_0010, SEGXL_KIND_DATA, '0, 0, 16'h0000, 32'h0001_2350);
      acc(16'hFFFF, 32'h0000_0020, SEGXL_KIND_CODE, '0, 0, 16'h0000, 32'h0010_0010);
   endtask
   task t_tables;
      @(posedge clk);
      gtp_load <= 1'b1; gtp_base <= 32'h0001_0000; ltp_load <= 1'b1; ltp_base <= 32'h0002_0000;
      prot_enter <= 1'b1;
      @(posedge clk);
      gtp_load <= 1'b0; ltp_load <= 1'b0; ltp_clear <= 1'b1; prot_enter <= 1'b0;
      @(posedge clk);
      ltp_clear <= 1'b0;
      acc(16'h0003, 32'h0000_0004, SEGXL_KIND_DATA, '0, 1, 16'h0000, 32'h0000_0000);
      acc(16'h000C, 32'h0000_0004, SEGXL_KIND_DATA, '0, 1, 16'h0000, 32'h0000_0000);
      @(posedge clk);
      ltp_load <= 1'b1;
      @(posedge clk);
      ltp_load <= 1'b0;
   endtask
   task t_prot;
      acc(16'h0010, 32'h0000_0100, SEGXL_KIND_CODE, dsc(32'h0040_0000, 2'h0, 4'hA, 1), 0,
          16'h0000, 32'h0040_0100);
      chk(current_privilege_level, 32'h0000_0000, "privilege");
      acc(16'h0010, 32'h0000_0008, SEGXL_KIND_CODE,
          dsc(32'h0040_0000, 2'h0, 4'hE, 1) | 64'h0000_0080_0000_0000, 0,
          16'h0000, 32'h0040_0008);
      acc(16'h0010, 32'h0000_0008, SEGXL_KIND_CODE,
          dsc(32'h0040_0000, 2'h1, 4'hE, 1) | 64'h0000_0080_0000_0000, 1,
          16'h0010, 32'h0000_0000);
      chk(current_privilege_level, 32'h0000_0000, "privilege kept");
      slow <= 1'b1;
      acc(16'h001F, 32'h0000_0004, SEGXL_KIND_DATA, dsc(32'h0050_0000, 2'h3, 4'h2, 1), 0,
          16'h0000, 32'h0050_0004);
      acc(16'h001F, 32'h0000_0004, SEGXL_KIND_DATA, dsc(32'h0050_0000, 2'h2, 4'h2, 1), 1,
          16'h001C, 32'h0000_0000);
      slow <= 1'b0;
      acc(16'h0010, 32'h0000_0000, SEGXL_KIND_CODE, dsc(32'h0040_0000, 2'h2, 4'hA, 1), 1,
          16'h0010, 32'h0000_0000);
      acc(16'h0018, 32'h0000_0008, SEGXL_KIND_STACK, dsc(32'h0060_0000, 2'h0, 4'h2, 1), 0,
          16'h0000, 32'h0060_0008);
      acc(16'h0019, 32'h0000_0008, SEGXL_KIND_STACK, dsc(32'h0060_0000, 2'h0, 4'h2, 1), 1,
          16'h0018, 32'h0000_0000);
      acc(16'h0023, 32'h0000_0008, SEGXL_KIND_DATA, dsc(32'h0060_0000, 2'h3, 4'h2, 0), 1,
          16'h0020, 32'h0000_0000);
   endtask
   task t_rereset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk({prot_mode, current_privilege_level, req_ready}, 32'h0000_0001, "state after reset");
      acc(16'h0010, 32'h0000_0003, SEGXL_KIND_DATA, '0, 0, 16'h0000, 32'h0000_0103);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      t_real();
      t_tables();
      t_prot();
      t_rereset();
      end_of_test();
   end
endmodule
